// ===== rtl/rmask_top.sv
// Function
// RQ1 - Each mask bit enables its event source at one, disables it at zero.
// RQ2 - The mask resets to all zeros, every interrupt disabled.
// RQ3 - Bits 7..0: supply low, buffer violation, address match, ... lock.
// RQ4 - Reading pending flags returns them, then clears all and the pin.
// RQ5 - Pending flags are read-only, reset to zero, held until read.
// RQ6 - Request pin asserts while any pending flag has its mask bit set.
// RQ7 - Visibility off: masked events are not recorded.
// RQ8 - Visibility on (reset value): every event is recorded.
// RQ9 - Events recorded only by visibility never assert the request pin.
// RQ10 - Control bit 0 picks request pin level: zero high, one low.
// RQ11 - Buffer empty indication on the request pin is always active high.
// RQ12 - Level select does not alter receive buffer indicator control.
// RQ13 - Control bit 6 set: stamp pin rises at frame header reception.
// RQ14 - Stamp pin signals even with frame receive start masked.
// RQ15 - Stamp pin stays high until the frame procedure ends.
// RQ16 - Host reads pending flags after the request pin asserts.
// RQ17 - Host reads pending flags once before enabling an interrupt.
// RQ18 - Host reads pending flags before switching visibility on.
// RQ19 - Control resets with bits 5 and 1 set, others zero.
// RQ20 - Flags persist; synth lock and unlock clear each other.
// RQ21 - Synth unlock during transmit switches the power amplifier off.
// RQ22 - An event coinciding with a flag read survives to the next read.
`timescale 1ns/1ps
module rmask_top
   import rmask_pkg::*;
(
   // Clock and reset
   input  wire logic           clock_i,
   input  wire logic           reset_i,
   // Register access from the serial port engine
   input  wire rmask_reg_req_t reg_req_i,
   output logic [7:0]          reg_rdata_o,
   // Event sources, one-cycle pulses
   input  wire rmask_events_t  events_i,
   // Transceiver status
   input  wire logic           tx_active_i,
   input  wire logic           frame_header_rx_i,
   input  wire logic           frame_done_i,
   input  wire logic           fb_empty_ind_en_i,
   input  wire logic           fb_empty_i,
   // Pins and controls out
   output logic                irq_pin_o,
   output logic                timestamp_pin_o,
   output logic                pa_off_o,
   output logic                rx_buffer_indicator_ctrl_o,
   output logic                tx_auto_crc_o
);

   rmask_state_t st_r;
   rmask_state_t st_nxt;

   logic [7:0] ev_vec;
   logic [7:0] ev_rec;
   logic [7:0] pair_clr;
   logic       rd_pending;
   logic       req_any;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Address match for a strobe, used by read and write decode
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [5:0]        ofs);
      return a == ofs[ADDR_W-1:0];
   endfunction

   // ----------------------------------------------------------------
   // Event recording
   // ----------------------------------------------------------------
   // Struct order already places supply low at bit 7 and lock at bit 0
   assign ev_vec     = events_i;                        // [RQ3]
   assign rd_pending = reg_req_i.rd && hit(reg_req_i.addr, OFS_PENDING);

   // Visibility bit lets masked events through to the flags only
   always_comb begin
      if (st_r.ctrl[CTL_MASK_VIS]) begin
         ev_rec = ev_vec;                               // [RQ8]
      end else begin
         ev_rec = ev_vec & st_r.mask;                   // [RQ7] [RQ1]
      end
   end

   // A recorded lock wipes unlock and vice versa; when both come at
   // once both stay, so neither event is silently lost
   always_comb begin
      pair_clr = '0;
      pair_clr[EV_SYNTH_UNLOCK] = ev_rec[EV_SYNTH_LOCK];   // [RQ20]
      pair_clr[EV_SYNTH_LOCK]   = ev_rec[EV_SYNTH_UNLOCK]; // [RQ20]
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;

      // Register writes; pending flags ignore writes
      if (reg_req_i.wr) begin
         if (hit(reg_req_i.addr, OFS_CONTROL_ONE)) begin
            st_nxt.ctrl = reg_req_i.wdata;
         end
         if (hit(reg_req_i.addr, OFS_IRQ_MASK)) begin
            st_nxt.mask = reg_req_i.wdata;              // [RQ1]
         end
      end

      // Read data returns the flags as they stand before the clear
      if (reg_req_i.rd) begin
         if (hit(reg_req_i.addr, OFS_CONTROL_ONE)) begin
            st_nxt.rdata = st_r.ctrl;
         end else if (hit(reg_req_i.addr, OFS_IRQ_MASK)) begin
            st_nxt.rdata = st_r.mask;
         end else if (rd_pending) begin
            st_nxt.rdata = st_r.flags;                  // [RQ4]
         end else begin
            st_nxt.rdata = UNMAPPED_DATA;
         end
      end

      // Clear on read, then new events set: set beats clear
      st_nxt.flags = rd_pending ? RST_PENDING : st_r.flags; // [RQ4] [RQ5]
      st_nxt.flags = (st_nxt.flags & ~pair_clr) | ev_rec;   // [RQ22]

      // Pin follows the enabled flags; visibility-only flags have a
      // zero mask bit and so stay silent. Buffer empty use overrides
      req_any = |(st_nxt.flags & st_nxt.mask);          // [RQ6] [RQ9]
      if (fb_empty_ind_en_i) begin
         st_nxt.irq_pin = fb_empty_i;                   // [RQ11]
      end else begin
         st_nxt.irq_pin = req_any ^ st_nxt.ctrl[CTL_LEVEL_SEL]; // [RQ10]
      end

      // Amplifier cut on unlock while sending, held for the transmit
      if (!tx_active_i) begin
         st_nxt.pa_off = 1'b0;
      end else if (ev_vec[EV_SYNTH_UNLOCK]) begin
         st_nxt.pa_off = 1'b1;                          // [RQ21]
      end
   end

   // State register; the pin idles low, which is inactive at reset
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         st_r.ctrl    <= RST_CONTROL_ONE;               // [RQ19]
         st_r.mask    <= RST_IRQ_MASK;                  // [RQ2]
         st_r.flags   <= RST_PENDING;                   // [RQ5]
         st_r.rdata   <= RST_READ_DATA;
         st_r.irq_pin <= 1'b0;
         st_r.pa_off  <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Receive buffer control leaves straight from its bit, untouched
   // by the level select
   assign reg_rdata_o                = st_r.rdata;
   assign irq_pin_o                  = st_r.irq_pin;
   assign pa_off_o                   = st_r.pa_off;
   assign rx_buffer_indicator_ctrl_o = st_r.ctrl[CTL_RX_BL]; // [RQ12]
   assign tx_auto_crc_o              = st_r.ctrl[CTL_TX_CRC];

   // Time-stamp pin driver
   rmask_stamp u_stamp (
      .clock_i         (clock_i),
      .reset_i         (reset_i),
      .enable_i        (st_r.ctrl[CTL_STAMP_EN]),       // [RQ13]
      .header_rx_i     (frame_header_rx_i),
      .frame_done_i    (frame_done_i),
      .timestamp_pin_o (timestamp_pin_o)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);

   sequence s_mask_write;
      reg_req_i.wr && hit(reg_req_i.addr, OFS_IRQ_MASK);
   endsequence

   sequence s_quiet_read;
      rd_pending && (ev_vec == 8'h00);
   endsequence

   chk_mask_write: assert property ( // [RQ1]
      s_mask_write |=> st_r.mask == $past(reg_req_i.wdata))
      else $error("mask write not stored");

   chk_mask_reset: assert property ( // [RQ2]
      @(posedge clock_i) disable iff (1'b0)
      reset_i |=> (st_r.mask == 8'h00) && (st_r.ctrl == 8'h22))
      else $error("mask or control reset value wrong");

   chk_read_clear: assert property ( // [RQ4]
      s_quiet_read |=> (st_r.flags == 8'h00)
                       && (reg_rdata_o == $past(st_r.flags)))
      else $error("flag read did not return and clear");

   chk_pin_level: assert property ( // [RQ6]
      !$past(fb_empty_ind_en_i) |->
         irq_pin_o == ((|(st_r.flags & st_r.mask))
                       ^ st_r.ctrl[CTL_LEVEL_SEL]))
      else $error("request pin disagrees with flags and mask");

   chk_hidden_event: assert property ( // [RQ7]
      rd_pending && !st_r.ctrl[CTL_MASK_VIS] && (st_r.mask == st_nxt.mask)
      |=> (st_r.flags & ~st_r.mask) == 8'h00)
      else $error("masked event recorded with visibility off");

   chk_visible_event: assert property ( // [RQ8]
      st_r.ctrl[CTL_MASK_VIS] && (ev_vec != 8'h00)
      |=> (st_r.flags & $past(ev_vec)) == $past(ev_vec))
      else $error("visible event not recorded");

   chk_read_race: assert property ( // [RQ22]
      rd_pending && (ev_rec != 8'h00) |=> st_r.flags == $past(ev_rec))
      else $error("event lost in read clear");

   chk_lock_pair: assert property ( // [RQ20]
      ev_rec[EV_SYNTH_LOCK] && !ev_rec[EV_SYNTH_UNLOCK]
      |=> st_r.flags[EV_SYNTH_LOCK] && !st_r.flags[EV_SYNTH_UNLOCK])
      else $error("lock did not clear unlock");

   chk_pa_cut: assert property ( // [RQ21]
      ev_vec[EV_SYNTH_UNLOCK] && tx_active_i |=> pa_off_o)
      else $error("amplifier not cut on unlock");

   chk_empty_high: assert property ( // [RQ11]
      fb_empty_ind_en_i && fb_empty_i |=> irq_pin_o)
      else $error("buffer empty indication not high");

endmodule

// ===== pkg/rmask_pkg.sv
package rmask_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W           = 6;
   localparam logic [5:0]  OFS_CONTROL_ONE  = 6'h04;
   localparam logic [5:0]  OFS_IRQ_MASK     = 6'h0E;
   localparam logic [5:0]  OFS_PENDING      = 6'h0F;

   // Reset values
   localparam logic [7:0]  RST_CONTROL_ONE  = 8'h22;
   localparam logic [7:0]  RST_IRQ_MASK     = 8'h00;
   localparam logic [7:0]  RST_PENDING      = 8'h00;
   localparam logic [7:0]  RST_READ_DATA    = 8'h00;
   localparam logic [7:0]  UNMAPPED_DATA    = 8'h00;

   // ----------------------------------------------------------------
   // Field positions in control_one
   // ----------------------------------------------------------------
   localparam int unsigned CTL_LEVEL_SEL    = 0;
   localparam int unsigned CTL_MASK_VIS     = 1;
   localparam int unsigned CTL_RX_BL        = 4;
   localparam int unsigned CTL_TX_CRC       = 5;
   localparam int unsigned CTL_STAMP_EN     = 6;

   // ----------------------------------------------------------------
   // Event bit positions in mask and pending flags
   // ----------------------------------------------------------------
   localparam int unsigned EV_SYNTH_LOCK    = 0;
   localparam int unsigned EV_SYNTH_UNLOCK  = 1;
   localparam int unsigned EV_FRAME_RX_ST   = 2;
   localparam int unsigned EV_FRAME_END     = 3;
   localparam int unsigned EV_CHAN_DONE     = 4;
   localparam int unsigned EV_ADDR_MATCH    = 5;
   localparam int unsigned EV_BUF_VIOL      = 6;
   localparam int unsigned EV_SUPPLY_LOW    = 7;

   // Event sources, bit 7 down to bit 0
   typedef struct packed {
      logic supply_low_event;
      logic buffer_access_violation_event;
      logic address_match_event;
      logic channel_assess_done_event;
      logic frame_end_event;
      logic frame_rx_start_event;
      logic synth_unlock_event;
      logic synth_lock_event;
   } rmask_events_t;

   // Register access strobes from the serial port engine
   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        wdata;
   } rmask_reg_req_t;

   // Complete state of the collection logic
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] mask;
      logic [7:0] flags;
      logic [7:0] rdata;
      logic       irq_pin;
      logic       pa_off;
   } rmask_state_t;

   // State of the time-stamp pin driver
   typedef struct packed {
      logic pin;
   } rmask_stamp_state_t;

endpackage

// ===== rtl/rmask_stamp.sv
`timescale 1ns/1ps
module rmask_stamp
   import rmask_pkg::*;
(
   // Clock and reset
   input  wire logic clock_i,
   input  wire logic reset_i,
   // Control and frame timing
   input  wire logic enable_i,
   input  wire logic header_rx_i,
   input  wire logic frame_done_i,
   // Pin
   output logic      timestamp_pin_o
);

   rmask_stamp_state_t st_r;
   rmask_stamp_state_t st_nxt;

   // ----------------------------------------------------------------
   // Pin level
   // ----------------------------------------------------------------
   // Raised at the header, independent of the interrupt mask; held
   // until the frame procedure ends. Header wins over a same-cycle end
   always_comb begin
      st_nxt = st_r;
      if (!enable_i) begin
         st_nxt.pin = 1'b0;
      end else if (header_rx_i) begin
         st_nxt.pin = 1'b1;              // [RQ13] [RQ14]
      end else if (frame_done_i) begin
         st_nxt.pin = 1'b0;              // [RQ15]
      end
   end

   // State register
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign timestamp_pin_o = st_r.pin;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_header_seen;
      enable_i && header_rx_i;
   endsequence

   sequence s_held_open;
      timestamp_pin_o && enable_i && !frame_done_i;
   endsequence

   chk_stamp_rise: assert property ( // [RQ13]
      @(posedge clock_i) disable iff (reset_i)
      s_header_seen |=> timestamp_pin_o)
      else $error("stamp pin not raised at header");

   chk_stamp_hold: assert property ( // [RQ15]
      @(posedge clock_i) disable iff (reset_i)
      s_held_open |=> timestamp_pin_o)
      else $error("stamp pin dropped before frame end");

   chk_stamp_off: assert property ( // [RQ13]
      @(posedge clock_i) disable iff (reset_i)
      !enable_i |=> !timestamp_pin_o)
      else $error("stamp pin high while disabled");

endmodule

// ===== bench/rmask_host.sv
`timescale 1ns/1ps
module rmask_host
   import rmask_pkg::*;
(
   // Clock
   input  wire logic     clock_i,
   // Register strobes towards the device
   output rmask_reg_req_t req_o
);
   // ------------------------------------------------------------
   // Register access: one strobe, then idle
   // ------------------------------------------------------------
   // Nothing requested before the first edge
   initial req_o = '0;

   // Idle address and data flip, so a stale value is never trusted
   task automatic access(input logic w, input logic [5:0] a,
                         input logic [7:0] d);
      @(posedge clock_i);
      req_o <= '{w, !w, a, d};
      @(posedge clock_i);
      req_o <= '{1'b0, 1'b0, ~a, ~d};
   endtask

   // Find the cause and drop stale flags before enabling or polling
   task automatic service();
      access(1'b0, 6'h0F, 8'h00);
   endtask
endmodule

// ===== bench/testbench.sv
`timescale 1ns/1ps
module testbench;
   import rmask_pkg::*;
   logic           clock_i = 0;
   logic           reset_i = 1;
   logic           tx_act  = 0;
   logic           hdr     = 0;
   logic           done    = 0;
   logic           fb_en   = 0;
   logic           fb      = 0;
   rmask_events_t  ev      = '0;
   rmask_reg_req_t req;
   logic [7:0]     rdata;
   logic           irq, stamp, pa, rxbl, crc;
   logic [7:0]     m_ctrl, m_mask, m_flags, m_rdata, rec, nf;
   logic           m_irq, m_stamp, m_pa;
   int             miscompares = 0;
   int             total_checks = 0;
   int             rnd;

   rmask_top i_dut (.clock_i(clock_i), .reset_i(reset_i), .reg_req_i(req),
      .reg_rdata_o(rdata), .events_i(ev), .tx_active_i(tx_act),
      .frame_header_rx_i(hdr), .frame_done_i(done),
      .fb_empty_ind_en_i(fb_en), .fb_empty_i(fb), .irq_pin_o(irq),
      .timestamp_pin_o(stamp), .pa_off_o(pa),
      .rx_buffer_indicator_ctrl_o(rxbl), .tx_auto_crc_o(crc));
   rmask_host i_host (.clock_i(clock_i), .req_o(req));

   // Clock at 10 MHz
   always #50 clock_i = ~clock_i;

   // ------------------------------------------------------------
   // Reference model, stepped on the same edge as the device
   // ------------------------------------------------------------
   always @(posedge clock_i) begin
      if (reset_i) begin
         {m_ctrl, m_mask, m_flags, m_rdata} = 32'h2200_0000;
         {m_irq, m_stamp, m_pa} = 3'h0;
      end else begin
         if (req.rd) begin
            m_rdata = req.addr == 6'h04 ? m_ctrl : req.addr == 6'h0E ?
                      m_mask : req.addr == 6'h0F ? m_flags : 8'h00;
         end
         // Set wins over the read clear, so coinciding events survive
         nf = (req.rd && req.addr == 6'h0F) ? 8'h00 : m_flags;
         rec = ev & (m_ctrl[1] ? 8'hFF : m_mask);
         nf = nf | rec;
         if (rec[0] && !rec[1]) nf[1] = 1'b0;
         if (rec[1] && !rec[0]) nf[0] = 1'b0;
         m_flags = nf;
         if (hdr && m_ctrl[6]) m_stamp = 1'b1;
         else if (done || !m_ctrl[6]) m_stamp = 1'b0;
         if (ev[1] && tx_act) m_pa = 1'b1;
         else if (!tx_act) m_pa = 1'b0;
         if (req.wr && req.addr == 6'h04) m_ctrl = req.wdata;
         if (req.wr && req.addr == 6'h0E) m_mask = req.wdata;
         m_irq = fb_en ? fb : ((m_flags & m_mask) != 0) ^ m_ctrl[0];
      end
   end

   task automatic check(input string n, input logic [7:0] s,
                        input logic [7:0] e);
      total_checks++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask

   // Outputs are settled mid-cycle, compare every cycle there
   always @(negedge clock_i) begin
      if (!reset_i) begin
         check("rdata", rdata, m_rdata); // Read path
         check("irq", 8'(irq), 8'(m_irq)); // Pin
         check("stamp", 8'(stamp), 8'(m_stamp)); // Pin
         check("pa_off", 8'(pa), 8'(m_pa)); // Amplifier cut
         check("rx_bl", 8'(rxbl), 8'(m_ctrl[4])); // Control
         check("crc", 8'(crc), 8'(m_ctrl[5])); // Control
      end
   end

   // ------------------------------------------------------------
   // Stimulus helpers
   // ------------------------------------------------------------
   task automatic w(input logic [5:0] a, input logic [7:0] d);
      i_host.access(1'b1, a, d);
   endtask
   task automatic r(input logic [5:0] a);
      i_host.access(1'b0, a, 8'h00);
   endtask
   task automatic pulse(input logic [7:0] e);
      @(posedge clock_i);
      ev <= e;
      @(posedge clock_i);
      ev <= '0;
   endtask
   task automatic frame(input logic h, input logic d);
      @(posedge clock_i);
      {hdr, done} <= {h, d};
      @(posedge clock_i);
      {hdr, done} <= 2'b00;
   endtask

   task automatic final_report();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // Watchdog, far beyond the few hundred cycles the run needs
   initial begin
      #(100 * 5000);
      miscompares++;
      final_report();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      rnd = $urandom(32'ha057_a770);
      repeat (2) @(posedge clock_i);
      reset_i <= 1'b0;
      r(6'h04); // Control reset value
      r(6'h0E); // Mask reset value
      w(6'h0F, 8'hFF); // Flags are read-only
      r(6'h0F); // Flags stay clear
      r(6'h3A); // Unmapped place reads zero
      pulse(8'hFC); // Masked events seen, pin quiet
      repeat (3) @(posedge clock_i);
      r(6'h0F); // Flags held until read
      r(6'h0F); // Read cleared them
      w(6'h04, 8'h20); // Polling off
      i_host.service();
      w(6'h0E, 8'h08); // One source enabled
      pulse(8'hFF); // Only the enabled event lands
      i_host.service(); // Pin seen, cause read
      i_host.service(); // Stale flags dropped before enabling
      w(6'h0E, 8'h03);
      pulse(8'h01);
      pulse(8'h02); // Unlock displaces lock
      r(6'h0F); // Only unlock left
      w(6'h04, 8'h31); // Active low pin, buffer indicator on
      pulse(8'h01);
      r(6'h0F); // Pin returns to idle level
      fb_en <= 1'b1;
      fb <= 1'b1;
      repeat (3) @(posedge clock_i);
      fb <= 1'b0; // Empty indicator stays active high
      repeat (2) @(posedge clock_i);
      fb_en <= 1'b0;
      i_host.service(); // History cleared before polling returns
      w(6'h04, 8'h42); // Stamp pin on, receive start masked
      w(6'h0E, 8'h00);
      frame(1'b1, 1'b0); // Header raises the pin
      repeat (4) @(posedge clock_i);
      frame(1'b0, 1'b1); // Held until the frame ends
      frame(1'b1, 1'b1);
      frame(1'b0, 1'b1);
      tx_act <= 1'b1;
      pulse(8'h02); // Unlock during transmit
      repeat (3) @(posedge clock_i);
      tx_act <= 1'b0;
      // Random events race random register traffic
      fork
         repeat (150) begin
            rnd = $urandom % 5;
            i_host.access(1'($urandom), rnd == 0 ? 6'h04 : rnd == 1 ?
               6'h0E : rnd == 4 ? 6'h2A : 6'h0F, 8'($urandom));
         end
         repeat (300) begin
            @(posedge clock_i);
            ev <= 8'($urandom);
            tx_act <= 1'($urandom);
            fb_en <= ($urandom % 8) == 0;
            fb <= 1'($urandom);
         end
      join
      // Both branches drove on the last edge; let it pass before idling
      @(posedge clock_i);
      ev <= '0;
      tx_act <= 1'b0;
      fb_en <= 1'b0;
      fb <= 1'b0;
      reset_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      reset_i <= 1'b0;
      r(6'h0F); // Clear again after a second reset
      r(6'h04); // Control back to reset value
      final_report();
   end
endmodule
